// File: include/imt_map.svh
`ifndef IMT_MAP_SVH
`define IMT_MAP_SVH

`define IMT_OFF_CTL_SET  8'h00
`define IMT_OFF_STAT     8'h04
`define IMT_OFF_SHIFT    8'h08
`define IMT_OFF_ADR      8'h0c
`define IMT_OFF_HIGH_PER 8'h10
`define IMT_OFF_LOW_PER  8'h14
`define IMT_OFF_CTL_CLR  8'h18

`define IMT_B_EN         6
`define IMT_B_START_REQ  5
`define IMT_B_STOP_REQ   4
`define IMT_B_SI         3
`define IMT_B_ACK_ASSERT 2
`define IMT_CTL_MASK 8'h7c

`define IMT_RST_CTL  8'h00
`define IMT_RST_ADR  8'h00
`define IMT_RST_SCL  16'h0004
`define IMT_ST_NONE  8'hf8

`define IMT_ST_START   8'h08
`define IMT_ST_RSTART  8'h10
`define IMT_ST_AW_ACK  8'h18
`define IMT_ST_AW_NACK 8'h20
`define IMT_ST_DT_ACK  8'h28
`define IMT_ST_DT_NACK 8'h30
`define IMT_ST_ARB     8'h38
`define IMT_ST_AR_ACK  8'h40
`define IMT_ST_AR_NACK 8'h48
`define IMT_ST_SR_OWN  8'h68
`define IMT_ST_SR_GC   8'h78
`define IMT_ST_ST_OWN  8'hb0

`endif

// File: include/imt_pkg.sv
`default_nettype none
package imt_pkg;
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_WAIT  = 4'h1,
        S_START = 4'h3,
        S_HOLD  = 4'h2,
        S_LOW   = 4'h6,
        S_HIGH  = 4'h7,
        S_STOP1 = 4'h5,
        S_STOP2 = 4'h4,
        S_STOP3 = 4'hc,
        S_RSTA1 = 4'hd,
        S_RSTA2 = 4'hf,
        S_SLV   = 4'he
    } imt_state_type;

    typedef struct packed {
        imt_state_type st;
        logic [7:0]    ctl;
        logic [7:0]    stat;
        logic [7:0]    shreg;
        logic [7:0]    adr;
        logic [15:0]   high_per;
        logic [15:0]   low_per;
        logic [3:0]    bitn;
        logic          addr_ph;
        logic          rep;
        logic          lost;
        logic          ack_me;
        logic          scl_low;
        logic          sda_low;
        logic [31:0]   rdata;
        logic          err;
    } imt_core_type;

    typedef struct packed {
        logic scl_m;
        logic sda_m;
        logic scl_s;
        logic sda_s;
        logic sda_d;
        logic busy;
    } imt_sync_type;
endpackage
`default_nettype wire

// File: include/imt_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface imt_link_if;
    logic        scl_s;
    logic        sda_s;
    logic        busy;
    logic        tmr_restart;
    logic [15:0] tmr_len;
    logic        tmr_done;
    modport syn  (output scl_s, sda_s, busy);
    modport tmr  (input tmr_restart, tmr_len, output tmr_done);
    modport core (input scl_s, sda_s, busy, tmr_done, output tmr_restart, tmr_len);
endinterface
`default_nettype wire

// File: core/imt_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module imt_pin_sync (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    imt_link_if.syn    lk
);
    import imt_pkg::*;

    imt_sync_type r;
    imt_sync_type n;

    always_comb begin
        n = r;
        n.scl_m = scl_in;
        n.sda_m = sda_in;
        n.scl_s = r.scl_m;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;
        // START falls on data with clock high; STOP rises
        if (r.scl_s && r.sda_d && !r.sda_s) begin
            n.busy = 1'b1;
        end else if (r.scl_s && !r.sda_d && r.sda_s) begin
            n.busy = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
                   sda_d: 1'b1, busy: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign lk.scl_s = r.scl_s;
    assign lk.sda_s = r.sda_s;
    assign lk.busy  = r.busy;
endmodule
`default_nettype wire

// File: core/imt_bit_timer.sv
`timescale 1ns/10ps
`default_nettype none
module imt_bit_timer #(
    parameter int W = 16
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    imt_link_if.tmr    lk
);
    import imt_pkg::*;

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // Saturates so a late reader still sees done
    always_comb begin
        cnt_nxt = cnt_r;
        if (lk.tmr_restart) begin
            cnt_nxt = '0;
        end else if (!lk.tmr_done) begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign lk.tmr_done = (cnt_r >= W'(lk.tmr_len));
endmodule
`default_nettype wire

// File: core/imt_master_tx.sv
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "imt_map.svh"
module imt_master_tx (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);
    import imt_pkg::*;

    imt_core_type r;
    imt_core_type n;
    logic         wr;
    logic         setup;
    logic         wait_hi;
    logic         si;
    logic         ack;
    logic [7:0]   nd;
    logic         acc;

    imt_link_if lk ();

    imt_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .lk      (lk.syn)
    );

    imt_bit_timer #(.W(16)) u_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk.tmr)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return hit(a, `IMT_OFF_CTL_SET) || hit(a, `IMT_OFF_STAT) ||
               hit(a, `IMT_OFF_SHIFT) || hit(a, `IMT_OFF_ADR) ||
               hit(a, `IMT_OFF_HIGH_PER) || hit(a, `IMT_OFF_LOW_PER) ||
               hit(a, `IMT_OFF_CTL_CLR);
    endfunction

    assign wr    = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign si    = r.ctl[`IMT_B_SI];
    assign ack   = !lk.sda_s;
    assign nd    = {r.shreg[6:0], lk.sda_s};
    // Clock stretching: high time counts only once SCL is seen high
    assign wait_hi = (r.st == S_HIGH || r.st == S_RSTA2 || r.st == S_STOP2)
                     && !lk.scl_s;
    // own address answered only with acknowledge-assert
    assign acc = r.addr_ph && r.ctl[`IMT_B_ACK_ASSERT] &&
                 (nd[7:1] == r.adr[7:1] || (nd == 8'h00 && r.adr[0]));

    assign lk.tmr_len = (r.st == S_LOW || r.st == S_STOP1 || r.st == S_RSTA1)
                        ? r.low_per : r.high_per;
    assign lk.tmr_restart = (n.st != r.st) || wait_hi;

    always_comb begin
        n = r;
        if (wr && hit(paddr, `IMT_OFF_CTL_CLR)) begin
            n.ctl = r.ctl & ~(pwdata[7:0] & `IMT_CTL_MASK);
        end
        // Shifting bytes must not be overwritten mid-flight
        if (wr && hit(paddr, `IMT_OFF_SHIFT) && (si || r.st == S_IDLE)) begin
            n.shreg = pwdata[7:0];
        end
        if (wr && hit(paddr, `IMT_OFF_ADR)) begin
            n.adr = pwdata[7:0];
        end
        if (wr && hit(paddr, `IMT_OFF_HIGH_PER)) begin
            n.high_per = pwdata[15:0];
        end
        if (wr && hit(paddr, `IMT_OFF_LOW_PER)) begin
            n.low_per = pwdata[15:0];
        end

        case (r.st)
            S_IDLE: begin
                if (r.ctl[`IMT_B_EN] && r.ctl[`IMT_B_START_REQ] && !si) begin
                    n.st = S_WAIT;
                end
            end
            S_WAIT: begin
                if (!lk.busy) begin
                    n.st      = S_START;
                    n.sda_low = 1'b1;
                    n.rep     = 1'b0;
                end
            end
            S_START: begin
                if (lk.tmr_done) begin
                    n.st      = S_HOLD;
                    n.scl_low = 1'b1;
                    n.addr_ph = 1'b1;
                    n.lost    = 1'b0;
                    n.ctl[`IMT_B_SI] = 1'b1;
                    n.stat = r.rep ? `IMT_ST_RSTART : `IMT_ST_START;
                end
            end
            S_HOLD: begin
                if (!si) begin
                    if (!r.addr_ph && r.ctl[`IMT_B_STOP_REQ]) begin
                        n.st      = S_STOP1;
                        n.sda_low = 1'b1;
                    end else if (!r.addr_ph && r.ctl[`IMT_B_START_REQ]) begin
                        n.st      = S_RSTA1;
                        n.sda_low = 1'b0;
                    end else begin
                        n.st      = S_LOW;
                        n.bitn    = 4'd0;
                        n.sda_low = !r.shreg[7];
                    end
                end
            end
            S_LOW: begin
                // Data moves a cycle after the clock falls, never with it
                n.sda_low = (r.bitn == 4'd8) ? r.ack_me : (!r.lost && !r.shreg[7]);
                if (lk.tmr_done) begin
                    n.st      = S_HIGH;
                    n.scl_low = 1'b0;
                end
            end
            S_HIGH: begin
                if (lk.tmr_done && r.bitn != 4'd8) begin
                    n.shreg   = nd;
                    n.bitn    = r.bitn + 4'd1;
                    n.st      = S_LOW;
                    n.scl_low = 1'b1;
                    if (!r.sda_low && !lk.sda_s) begin
                        n.lost = 1'b1;
                    end
                    if (r.bitn == 4'd7) begin
                        n.ack_me  = n.lost && acc;
                    end
                end else if (lk.tmr_done) begin
                    n.st      = r.lost ? S_SLV : S_HOLD;
                    n.scl_low = 1'b1;
                    n.addr_ph = 1'b0;
                    n.ack_me  = 1'b0;
                    n.ctl[`IMT_B_SI] = 1'b1;
                    if (r.lost) begin
                        if (!r.ack_me) begin
                            n.stat = `IMT_ST_ARB;
                        end else if (r.shreg == 8'h00) begin
                            n.stat = `IMT_ST_SR_GC;
                        end else begin
                            n.stat = r.shreg[0] ? `IMT_ST_ST_OWN : `IMT_ST_SR_OWN;
                        end
                    end else if (r.addr_ph && r.shreg[0]) begin
                        n.stat = ack ? `IMT_ST_AR_ACK : `IMT_ST_AR_NACK;
                    end else if (r.addr_ph) begin
                        n.stat = ack ? `IMT_ST_AW_ACK : `IMT_ST_AW_NACK;
                    end else begin
                        n.stat = ack ? `IMT_ST_DT_ACK : `IMT_ST_DT_NACK;
                    end
                end
            end
            S_SLV: begin
                // Own acknowledge let go while the clock is low
                n.sda_low = 1'b0;
                if (!si) begin
                    n.scl_low = 1'b0;
                    n.lost    = 1'b0;
                    n.st = r.ctl[`IMT_B_START_REQ] ? S_WAIT : S_IDLE;
                end
            end
            S_STOP1: begin
                if (lk.tmr_done) begin
                    n.st      = S_STOP2;
                    n.scl_low = 1'b0;
                end
            end
            S_STOP2: begin
                if (lk.tmr_done) begin
                    n.st      = S_STOP3;
                    n.sda_low = 1'b0;
                    n.ctl[`IMT_B_STOP_REQ] = 1'b0;
                end
            end
            S_STOP3: begin
                if (lk.tmr_done) begin
                    n.st = r.ctl[`IMT_B_START_REQ] ? S_WAIT : S_IDLE;
                end
            end
            S_RSTA1: begin
                if (lk.tmr_done) begin
                    n.st      = S_RSTA2;
                    n.scl_low = 1'b0;
                end
            end
            S_RSTA2: begin
                if (lk.tmr_done) begin
                    n.st      = S_START;
                    n.sda_low = 1'b1;
                    n.rep     = 1'b1;
                end
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase

        // disabled block lets go of the bus
        if (!r.ctl[`IMT_B_EN]) begin
            n.st      = S_IDLE;
            n.scl_low = 1'b0;
            n.sda_low = 1'b0;
            n.lost    = 1'b0;
        end

        // set address, applied last so set wins
        if (wr && hit(paddr, `IMT_OFF_CTL_SET)) begin
            n.ctl = n.ctl | (pwdata[7:0] & `IMT_CTL_MASK);
        end

        // Read data captured in setup, no wait states
        if (setup) begin
            n.err   = !mapped(paddr);
            n.rdata = 32'h0000_0000;
            if (hit(paddr, `IMT_OFF_CTL_SET)) begin
                n.rdata[7:0] = r.ctl;
            end else if (hit(paddr, `IMT_OFF_STAT)) begin
                n.rdata[7:0] = si ? r.stat : `IMT_ST_NONE;
            end else if (hit(paddr, `IMT_OFF_SHIFT)) begin
                n.rdata[7:0] = r.shreg;
            end else if (hit(paddr, `IMT_OFF_ADR)) begin
                n.rdata[7:0] = r.adr;
            end else if (hit(paddr, `IMT_OFF_HIGH_PER)) begin
                n.rdata[15:0] = r.high_per;
            end else if (hit(paddr, `IMT_OFF_LOW_PER)) begin
                n.rdata[15:0] = r.low_per;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: S_IDLE, ctl: `IMT_RST_CTL, stat: `IMT_ST_NONE,
                   shreg: 8'h00, adr: `IMT_RST_ADR, high_per: `IMT_RST_SCL,
                   low_per: `IMT_RST_SCL, bitn: 4'd0, addr_ph: 1'b0,
                   rep: 1'b0, lost: 1'b0, ack_me: 1'b0, scl_low: 1'b0,
                   sda_low: 1'b0, rdata: 32'h0000_0000, err: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign prdata  = r.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && r.err;
    assign scl_out = 1'b0;
    // clock held low by output enable
    assign scl_oe  = r.scl_low;
    assign sda_out = 1'b0;
    assign sda_oe  = r.sda_low;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_stat_hold;
        si && $past(si) |-> $stable(r.stat);
    endproperty
    a_stat_hold: assert property (p_stat_hold)
        else $error("status changed while flag set");

    property p_stat_low;
        r.stat[2:0] == 3'b000;
    endproperty
    a_stat_low: assert property (p_stat_low)
        else $error("status low bits not zero");

    property p_hold_scl;
        si && (r.st == S_HOLD || r.st == S_SLV) |-> scl_oe;
    endproperty
    a_hold_scl: assert property (p_hold_scl)
        else $error("clock released while flag set");

    property p_suspend;
        si && r.ctl[`IMT_B_EN] && r.st == S_HOLD |=> r.st == S_HOLD || !r.ctl[`IMT_B_EN];
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("bus moved while flag set");

    property p_start_code;
        $past(r.st) == S_START && r.st == S_HOLD |->
            si && (r.stat == `IMT_ST_START || r.stat == `IMT_ST_RSTART);
    endproperty
    a_start_code: assert property (p_start_code)
        else $error("START status missing");

    property p_free_start;
        r.st == S_WAIT && !lk.busy && r.ctl[`IMT_B_EN] |=> r.st == S_START ##0 sda_oe;
    endproperty
    a_free_start: assert property (p_free_start)
        else $error("START not sent on free bus");

    property p_rsta;
        r.st == S_HOLD && !si && !r.addr_ph && r.ctl[`IMT_B_START_REQ] &&
            !r.ctl[`IMT_B_STOP_REQ] && r.ctl[`IMT_B_EN] |=> r.st == S_RSTA1;
    endproperty
    a_rsta: assert property (p_rsta)
        else $error("repeated START not begun");

    property p_stop;
        r.st == S_HOLD && !si && !r.addr_ph && r.ctl[`IMT_B_STOP_REQ] &&
            r.ctl[`IMT_B_EN] |=> r.st == S_STOP1 ##0 scl_oe && sda_oe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("STOP not begun");

    property p_arb_release;
        r.lost && r.bitn != 4'd8 && r.st == S_LOW |-> !sda_oe;
    endproperty
    a_arb_release: assert property (p_arb_release)
        else $error("data driven after lost arbitration");

    property p_slave_codes;
        $rose(si) && (r.stat == `IMT_ST_SR_OWN || r.stat == `IMT_ST_ST_OWN)
            |-> $past(r.ack_me, 2) && r.st == S_SLV;
    endproperty
    a_slave_codes: assert property (p_slave_codes)
        else $error("slave status without address match");

    property p_ctl_set;
        wr && hit(paddr, `IMT_OFF_CTL_SET) && pwdata[`IMT_B_START_REQ]
            |=> r.ctl[`IMT_B_START_REQ];
    endproperty
    a_ctl_set: assert property (p_ctl_set)
        else $error("start request not set");

    c_data_ack: cover property ($rose(si) && r.stat == `IMT_ST_DT_ACK);
    c_arb_lost: cover property ($rose(r.lost));
    c_stop_done: cover property (r.st == S_STOP3 ##1 r.st == S_IDLE);
    c_rstart: cover property ($rose(si) && r.stat == `IMT_ST_RSTART);
endmodule
`default_nettype wire

// File: verif/imt_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module imt_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack_data,
    output var logic  sda_oe
);
    logic [7:0] sh;
    int         n;
    bit         act;
    bit         adr;
    int         q[$];

    initial begin
        sda_oe = 1'b0;
        act = 1'b0;
        n = 0;
    end

    // Conditions only count while the clock is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            adr = 1'b1;
            n = 0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b0;
        end
    end

    always @(posedge scl) begin
        if (act && n < 8) begin
            sh = {sh[6:0], sda};
            n++;
        end
    end

    // Release after one slot, never left holding the line
    always @(negedge scl) begin
        if (act && n == 8) begin
            sda_oe = adr ? (sh == {ADDR, 1'b0}) : !nack_data;
            if (!adr) begin
                q.push_back(int'(sh));
            end
            act = sda_oe | !adr;
            adr = 1'b0;
            n = 9;
        end else if (n == 9) begin
            sda_oe = 1'b0;
            n = 0;
        end
    end
endmodule
`default_nettype wire

// File: verif/i2c_master_transmit_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_transmit_sequencer_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl_oe;
    logic        sda_oe;
    logic        scl_out;
    logic        sda_out;
    logic        slv_oe;
    logic        comp_oe;
    logic        nack_last;
    wire logic   scl;
    wire logic   sda;
    int          n_fail;
    int          checks;
    int          exp_q[$];
    logic [31:0] r;
    logic        err;
    logic [7:0]  b;

    // Pull-ups on both lines
    assign scl = scl_oe ? scl_out : 1'b1;
    assign sda = !((sda_oe && !sda_out) || slv_oe || comp_oe);

    imt_master_tx dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .scl_in  (scl),
        .scl_out (scl_out),
        .scl_oe  (scl_oe),
        .sda_in  (sda),
        .sda_out (sda_out),
        .sda_oe  (sda_oe)
    );

    imt_slave_model #(.ADDR(7'h2a)) slv (
        .scl       (scl),
        .sda       (sda),
        .nack_data (nack_last),
        .sda_oe    (slv_oe)
    );

    always #5 pclk = ~pclk;

    task automatic final_report;
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load byte, edit control, wait for the flag, check status
    task automatic go(input logic [7:0] d, input logic [7:0] cs,
                      input logic [7:0] cc, input logic [7:0] e);
        int k;
        k = 0;
        apb(1'b1, 8'h08, {24'h0, d});
        if (cs != 8'h00) begin
            apb(1'b1, 8'h00, {24'h0, cs});
        end
        apb(1'b1, 8'h18, {24'h0, cc});
        r = 0;
        while (r[3] !== 1'b1 && k < 3000) begin
            apb(1'b0, 8'h00, 0);
            k++;
        end
        apb(1'b0, 8'h04, 0);
        chk(r, {24'h0, e});
        repeat (40) @(posedge pclk);
        apb(1'b0, 8'h04, 0);
        chk(r, {24'h0, e});
        if (e != 8'h38) begin
            chk({31'h0, scl}, 0);
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        comp_oe = 1'b0;
        nack_last = 1'b0;
        n_fail = 0;
        checks = 0;
        void'($urandom(58891));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 0);
        chk(r, 0);
        apb(1'b0, 8'h1c, 0);
        chk({31'h0, err}, 1);
        apb(1'b1, 8'h00, 32'h44);
        apb(1'b1, 8'h18, 32'h04);
        apb(1'b0, 8'h00, 0);
        chk(r, 32'h40);
        apb(1'b1, 8'h10, 32'h7);
        apb(1'b1, 8'h14, 32'h7);
        $display("test regs done");
        go(8'h00, 8'h20, 8'h00, 8'h08);
        go(8'h56, 8'h00, 8'h28, 8'h20);
        go(8'h00, 8'h20, 8'h08, 8'h10);
        go(8'h54, 8'h00, 8'h28, 8'h18);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom_range(0, 255));
            exp_q.push_back(int'(b));
            nack_last <= (i == 2);
            go(b, 8'h00, 8'h08, (i == 2) ? 8'h30 : 8'h28);
        end
        go(8'h00, 8'h30, 8'h08, 8'h08);
        apb(1'b0, 8'h00, 0);
        chk(r & 32'h10, 0);
        $display("test transmit done");
        comp_oe <= 1'b1;
        go(8'ha4, 8'h00, 8'h28, 8'h38);
        apb(1'b1, 8'h18, 32'h08);
        // Winner ends its frame with a STOP once the clock is free
        repeat (20) @(posedge pclk);
        comp_oe <= 1'b0;
        repeat (200) @(posedge pclk);
        chk({30'h0, scl, sda}, 3);
        apb(1'b0, 8'h04, 0);
        chk(r, 32'hf8);
        go(8'h00, 8'h20, 8'h00, 8'h08);
        go(8'h54, 8'h00, 8'h28, 8'h18);
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h18, 32'h08);
        repeat (300) @(posedge pclk);
        apb(1'b0, 8'h00, 0);
        chk(r, 32'h40);
        chk({31'h0, sda}, 1);
        chk(slv.q.size(), exp_q.size());
        foreach (exp_q[i]) chk(slv.q[i], exp_q[i]);
        $display("test arbitration and stop done");
        final_report;
    end

    // Whole run needs well under this span
    initial begin
        #400000;
        n_fail++;
        final_report;
    end
endmodule
`default_nettype wire
